// >>> bcs_cfg.svh
// How it works
// - Hold-low stretches bus clock by half periods
// - Stretch starts after high phase when timely
// - Late hold fall defers stretch one cycle
// - Timely hold release resumes at half end
// - Late release drops clock at second slot
// - Hold high gives plain divided clock
// - Bus clock is oscillator divided by four
// - Gate high lets RAM follow controls
// - Gate low blocks every RAM access
// - One bus clock out, showing stretches
// - Low 32 bytes and gate kept powered
// - RAM at 0000-007F drives data bus
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH
`define BCS_RAM_DEPTH     128
`define BCS_RAM_AW        7
`define BCS_RAM_KEEP      32
`define BCS_RAM_HI_ADDR   16'h007f
`define BCS_PH_RISE       2'h1
`define BCS_PH_FALL       2'h3
`define BCS_PH_HIGH2      2'h2
`define BCS_PH_IDLE       2'h0
`endif

// >>> bcs_pkg.sv
package bcs_pkg;
    typedef logic [1:0] bcs_phase_t;
    typedef logic [7:0] bcs_byte_t;
endpackage : bcs_pkg

// >>> bcs_clock_ram.sv
`timescale 1ns/100ps
`include "bcs_cfg.svh"
module bcs_clock_ram
    import bcs_pkg::*;
#(
    // RAM size, address width and retained bytes
    parameter int RAM_DEPTH = `BCS_RAM_DEPTH,
    parameter int RAM_AW    = `BCS_RAM_AW,
    parameter int RAM_KEEP  = `BCS_RAM_KEEP
)
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // Stretch control
    input  wire logic        slowMemoryHold,
    output logic             busClock,
    // On-chip RAM access
    input  wire logic        onchipRamGate,
    input  wire logic        standbyMode,
    input  wire logic [15:0] addr,
    input  wire logic        readNotWrite,
    input  wire logic        validAddr,
    input  wire logic [7:0]  wrData,
    output bcs_byte_t        rdData,
    output logic             dataDriveN
);

    // Synchroniser stages for the two pin inputs
    logic holdMeta_q;
    logic holdSync_q;
    logic gateMeta_q;
    logic gateSync_q;

    // Hold pin: two flops, idle high so reset shows no stretch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            holdMeta_q <= 1'b1;
            holdSync_q <= 1'b1;
        end else if (clkEn) begin
            holdMeta_q <= slowMemoryHold;
            holdSync_q <= holdMeta_q;
        end
    end

    // Gate pin: two flops, idle low so RAM stays shut after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gateMeta_q <= 1'b0;
            gateSync_q <= 1'b0;
        end else if (clkEn) begin
            gateMeta_q <= onchipRamGate;
            gateSync_q <= gateMeta_q;
        end
    end

    // Phase counter and stretch bookkeeping
    bcs_phase_t phase_q;
    bcs_phase_t phase_d;
    logic       halfOdd_q;
    logic       halfOdd_d;
    logic       atHighEnd;
    logic       holdLow;
    logic       stretch;
    logic       busClock_d;

    // End of the high phase is the only place a stretch may start
    assign atHighEnd = (phase_q == `BCS_PH_FALL);

    // Synced hold level; a late fall misses this slot by the sync delay
    assign holdLow = !holdSync_q;

    // Stretch in pairs of quad cycles: one pair is half a bus period.
    // An odd cycle always completes its pair, so release only lands
    // on a half-period boundary, the late case one half later.
    assign stretch = atHighEnd && (halfOdd_q || holdLow);

    // Odd marker flips on each held quad cycle
    assign halfOdd_d = stretch && !halfOdd_q;

    // Counter freezes while held, otherwise counts quad cycles
    assign phase_d = stretch ? phase_q : phase_q + 2'h1;

    // Bus clock high on phases one and two, and through any stretch
    assign busClock_d = stretch
                        || (phase_q == `BCS_PH_RISE)
                        || (phase_q == `BCS_PH_HIGH2);

    // Phase counter on the quad-rate clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q <= `BCS_PH_IDLE;
        end else if (clkEn) begin
            phase_q <= phase_d;
        end
    end

    // Half-period parity of the current stretch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            halfOdd_q <= 1'b0;
        end else if (clkEn) begin
            halfOdd_q <= halfOdd_d;
        end
    end

    // Registered bus clock, so the pin carries no decode glitches
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busClock <= 1'b0;
        end else if (clkEn) begin
            busClock <= busClock_d;
        end
    end

    // RAM storage, not reset: contents survive a processor reset
    bcs_byte_t         mem [RAM_DEPTH];
    logic [RAM_AW-1:0] idx;
    logic              inWindow;
    logic              hit;
    logic              rdHit;
    logic              wrHit;
    logic              inKeep;
    logic              wrSlot;
    logic              wrStb;

    // Word index from the low address bits
    assign idx = addr[RAM_AW-1:0];

    // Full decode of the low window, so no alias above it
    assign inWindow = (addr <= `BCS_RAM_HI_ADDR);

    // Gate low blocks both directions at once
    assign hit = validAddr && gateSync_q && inWindow;

    // Split by direction
    assign rdHit = hit && readNotWrite;
    assign wrHit = hit && !readNotWrite;

    // Only the low bytes sit on the standby supply
    assign inKeep = (idx < RAM_AW'(RAM_KEEP));

    // Write early in the high phase, once per bus cycle
    assign wrSlot = busClock && (phase_q == `BCS_PH_HIGH2);

    // In standby the unpowered upper bytes take no writes
    assign wrStb = wrHit && wrSlot && (!standbyMode || inKeep);

    // Storage write port
    always_ff @(posedge clock) begin
        if (clkEn && wrStb) begin
            mem[idx] <= wrData;
        end
    end

    // Bus drive enable; low while the device owns the data bus
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dataDriveN <= 1'b1;
        end else if (clkEn) begin
            dataDriveN <= !rdHit;
        end
    end

    // Read data, zero when not a read hit to keep the bus quiet
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData <= 8'h00;
        end else if (clkEn) begin
            if (rdHit) begin
                rdData <= mem[idx];
            end else begin
                rdData <= 8'h00;
            end
        end
    end

    // Limitation: a hold longer than one bus cycle keeps stretching;
    // the far side must release in time, nothing here cuts it short.
    // Trade-off: stretch granularity is a half period, not a quad cycle,
    // so the counter can simply freeze at its last phase.

endmodule : bcs_clock_ram

// >>> bcs_clock_ram_sva.sv
`timescale 1ns/100ps
module bcs_clock_ram_sva (
    input wire logic        clock, rst_n, clkEn, slowMemoryHold, busClock, onchipRamGate,
    input wire logic        validAddr, readNotWrite, dataDriveN,
    input wire logic [15:0] addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire hit = validAddr && readNotWrite && addr <= 16'h007f;
    sequence s_held; (!slowMemoryHold && clkEn)[*4]; endsequence
    property p_div; (slowMemoryHold && clkEn)[*8] |-> busClock != $past(busClock, 2); endproperty
    a_div: assert property (p_div) else $error("divide");
    property p_str; s_held |-> ##[1:8] $stable(busClock)[*2]; endproperty
    a_str: assert property (p_str) else $error("stretch");
    property p_hit; onchipRamGate[*4] ##0 (hit && clkEn) |=> !dataDriveN; endproperty
    a_hit: assert property (p_hit) else $error("hit");
    property p_miss; clkEn && !hit |=> dataDriveN; endproperty
    a_miss: assert property (p_miss) else $error("miss");
    property p_freeze; !clkEn |=> $stable(busClock) && $stable(dataDriveN); endproperty
    a_freeze: assert property (p_freeze) else $error("freeze");
    property p_gate_off; (!onchipRamGate && clkEn)[*3] |=> dataDriveN; endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate off");
endmodule : bcs_clock_ram_sva
bind bcs_clock_ram bcs_clock_ram_sva u_sva (.*);

// >>> bcs_mem_model.sv
`timescale 1ns/100ps
module bcs_mem_model (input wire logic clock, go, output logic slowMemoryHold);
    logic [2:0] cnt_q = 3'h0;
    initial slowMemoryHold = 1'b1;
    // Low for four quad cycles; longer would exceed the one-cycle stretch
    always @(posedge clock) begin
        cnt_q <= go ? 3'h4 : cnt_q - 3'(cnt_q != 3'h0);
        slowMemoryHold <= !(go || cnt_q > 3'h1);
    end
endmodule : bcs_mem_model

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clock = 0, rst_n = 0, gate = 0, sb = 0, rnw = 1, va = 0, go = 0, ce = 1, hold, bc, drvN;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00, rd;
    int          n_errors = 0, checks = 0, m;
    // Control nibble: gate, standby, read, expected drive-off
    logic [35:0] rows [9] = '{36'h90010a500, 36'ha001000a5, 36'h9007f3c00, 36'ha007f003c,
        36'hb00800000, 36'h900401100, 36'hd0040ff00, 36'ha00400011, 36'h300100000};
    always #10 clock = !clock;
    bcs_mem_model mem (.clock(clock), .go(go), .slowMemoryHold(hold));
    bcs_clock_ram dut (.clock(clock), .rst_n(rst_n), .clkEn(ce), .slowMemoryHold(hold),
        .busClock(bc), .onchipRamGate(gate), .standbyMode(sb), .addr(addr),
        .readNotWrite(rnw), .validAddr(va), .wrData(wd), .rdData(rd), .dataDriveN(drvN));
    task chk(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // Longest run of equal bus clock samples over 40 cycles
    task run(input logic g);
        int c;
        logic p;
        m = 0; c = 0; p = bc; go = g;
        repeat (40) begin
            @(posedge clock);
            #1 go = 0;
            c = (bc === p) ? c + 1 : 1;
            p = bc;
            if (c > m) m = c;
        end
    endtask : run
    task results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clock);
        #1 chk("reset", {rd, bc, drvN}, 32'h1);
        rst_n = 1;
        repeat (3) @(posedge clock);
        // Held five cycles so a write always spans the high phase
        foreach (rows[i]) begin
            #1 {gate, sb, rnw} = rows[i][35:33];
            {addr, wd} = rows[i][31:8];
            va = 1;
            repeat (5) @(posedge clock);
            #1 chk("dataDriveN", drvN, rows[i][32]);
            chk("rdData", rd, rows[i][7:0]);
            va = 0;
            @(posedge clock);
            $display("row %0d done", i);
        end
        run(0);
        chk("plain", m, 2);
        run(1);
        chk("stretch", m == 4 || m == 6, 1);
        $display("clock tests done");
        ce = 0;
        m = bc;
        repeat (6) @(posedge clock);
        #1 chk("freeze", bc, m);
        ce = 1;
        $display("freeze test done");
        @(posedge clock);
        #1 rst_n = 0;
        @(posedge clock);
        #1 chk("midreset", {rd, bc, drvN}, 32'h1);
        rst_n = 1;
        run(0);
        chk("replain", m, 2);
        $display("reset test done");
        results();
    end
endmodule : testbench
